// [common/astc_pkg.sv]
package astc_pkg;
   // register indices; byte address is four times the index
   localparam logic [3:0]  IDX_CFG    = 4'h0;
   localparam logic [3:0]  IDX_TIMING = 4'h4;
   localparam logic [3:0]  IDX_START  = 4'h5;
   localparam logic [3:0]  IDX_STATUS = 4'h6;
   localparam int          ADDR_W     = 8;
   localparam logic [7:0]  ADDR_CFG    = {2'h0, IDX_CFG, 2'h0};
   localparam logic [7:0]  ADDR_TIMING = {2'h0, IDX_TIMING, 2'h0};
   localparam logic [7:0]  ADDR_START  = {2'h0, IDX_START, 2'h0};
   localparam logic [7:0]  ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
   // timing register fields
   localparam int          SMP_MSB = 7;
   localparam int          SMP_LSB = 5;
   localparam int          PRS_MSB = 4;
   // start register fields
   localparam int          SC_BIT   = 6;
   localparam int          SCAN_BIT = 5;
   localparam int          MULTI_CHANNEL_ENABLE_BIT = 4;
   localparam int          CH_MSB   = 3;
   // config register fields: wrap, length, trigger enable
   localparam int          WRAP_MSB  = 3;
   localparam int          LEN_LSB   = 4;
   localparam int          LEN_MSB   = 7;
   localparam int          ETRIG_BIT = 8;
   localparam logic [8:0]  CFG_RST    = 9'h04f;
   localparam logic [7:0]  TIMING_RST = 8'h00;
   localparam logic [7:0]  START_RST  = 8'h00;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam logic [4:0]  LEN_ZERO_COUNT = 5'h10;

   // command towards the multiplexer and converter core
   typedef struct packed {
      logic       start;
      logic       sample;
      logic       special;
      logic [3:0] channel;
   } astc_cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h1,
      ST_SAMPLE  = 3'h2,
      ST_CONVERT = 3'h4
   } astc_state_t;

   // sample length in conversion clocks
   function automatic logic [4:0] astc_samp_len(input logic [2:0] c);
      case (c)
         3'h0:    return 5'h04;
         3'h1:    return 5'h06;
         3'h2:    return 5'h08;
         3'h3:    return 5'h0a;
         3'h4:    return 5'h0c;
         3'h5:    return 5'h10;
         3'h6:    return 5'h14;
         default: return 5'h18;
      endcase
   endfunction : astc_samp_len

   function automatic logic [4:0] astc_seq_len(input logic [3:0] b);
      return (b == 4'h0) ? LEN_ZERO_COUNT : {1'b0, b};
   endfunction : astc_seq_len

   // increment wraps after the wrap channel, and naturally from 15 to 0
   function automatic logic [3:0] astc_step(input logic [3:0] ch, input logic [3:0] wrap);
      return (ch == wrap) ? 4'h0 : ch + 4'h1;
   endfunction : astc_step
endpackage : astc_pkg

// [verif/astc_core_model.sv]
`timescale 1ns/100ps
// behavioural converter core: one done pulse per finished sample phase
module astc_core_model
   import astc_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // command in, answer out
   input  wire astc_cmd_t  cmd,
   input  wire logic [3:0] lat,
   output logic            conv_done
);
   logic       samp_q;
   logic       owed;
   logic [3:0] wait_cnt;

   // conversion time runs from the end of sampling; a fresh start cancels an answer still owed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         samp_q    <= 1'b0;
         owed      <= 1'b0;
         wait_cnt  <= 4'h0;
         conv_done <= 1'b0;
      end else begin
         samp_q    <= cmd.sample;
         conv_done <= 1'b0;
         if (cmd.start) begin
            owed <= 1'b0;
         end else if (samp_q && !cmd.sample) begin
            owed     <= 1'b1;
            wait_cnt <= lat; // slow or prompt, as the bench sets lat
         end else if (owed) begin
            if (wait_cnt == 4'h0) begin
               conv_done <= 1'b1;
               owed      <= 1'b0;
            end else begin
               wait_cnt <= wait_cnt - 4'h1;
            end
         end
      end
   end
endmodule : astc_core_model

// [verif/astc_top_tb.sv]
`timescale 1ns/100ps
module astc_top_tb import astc_pkg::*;;
   logic        clk = 0, rst = 1, ce = 1, ext_trigger = 0;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_done, conv_clk, cc_q;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [3:0]  result_slot, lat = 4'h1;
   astc_cmd_t   cmd;
   logic [4:0]  seen[$];
   int          mismatches = 0, tests_run = 0, cyc = 0, samp_cnt = 0, last_rise = 0, period = 0, n;
   int          smp[8] = '{4, 6, 8, 10, 12, 16, 20, 24};

   astc_top i_dut (.clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .ext_trigger, .conv_done, .cmd, .conv_clk, .result_slot);
   astc_core_model i_core (.clk, .rst, .cmd, .lat, .conv_done);

   always #5 clk = ~clk;

   // monitor: starts, sample length, divided clock period, and the hang limit
   always @(posedge clk) begin
      cyc++;
      if (cmd.sample) samp_cnt++;
      if (cmd.start) seen.push_back({cmd.special, cmd.channel});
      if (conv_clk && !cc_q) begin
         period    = cyc - last_rise;
         last_rise = cyc;
      end
      cc_q = conv_clk;
      if (cyc > 40000) begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_rng(input int got, input int lo, input int hi);
      tests_run++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("unexpected at %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask : chk_rng

   // write: address and data offered together, each released when taken
   // bready and rready stay high between calls, so back-to-back calls never drive them twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic ta, tw;
      ta = 0;
      tw = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid  <= 1;
      s_axi_bready  <= 1;
      while (!(ta && tw)) begin
         @(posedge clk);
         if (!ta && s_axi_awready) begin
            ta = 1;
            s_axi_awvalid <= 0;
         end
         if (!tw && s_axi_wready) begin
            tw = 1;
            s_axi_wvalid <= 0;
         end
      end
      while (!s_axi_bvalid) @(posedge clk);
      rs = s_axi_bresp;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1;
      s_axi_rready  <= 1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge clk); while (!s_axi_rvalid);
      v = s_axi_rdata;
      rs = s_axi_rresp;
   endtask : rd

   task automatic wrc(input logic [7:0] a, input logic [31:0] v);
      wr(a, v, r);
      chk(r, RESP_OKAY);
   endtask : wrc

   // poll the busy flag; bounded so a stuck sequence ends in a mismatch
   task automatic wait_idle;
      repeat (2) @(posedge clk);
      d = 32'h100;
      for (int i = 0; i < 500 && d[8]; i++) rd(ADDR_STATUS, d, r);
      chk(d[8], 1'b0);
   endtask : wait_idle

   // run one sequence and compare every started channel with the stepping rules
   task automatic run_seq(input logic [8:0] cfgv, input logic [7:0] st);
      logic [3:0] ch;
      int         cnt;
      ch  = st[3:0];
      cnt = (cfgv[7:4] == 4'h0) ? 16 : int'(cfgv[7:4]);
      wrc(ADDR_CFG, 32'(cfgv));
      seen.delete();
      wrc(ADDR_START, 32'(st));
      wait_idle();
      chk(seen.size(), cnt);
      for (int i = 0; i < cnt; i++) begin
         chk(seen[i], {st[6], ch});
         if (st[4]) ch = (ch == cfgv[3:0]) ? 4'h0 : ch + 4'h1;
      end
   endtask : run_seq

   task automatic trig;
      ext_trigger <= 1;
      repeat (3) @(posedge clk);
      ext_trigger <= 0;
      repeat (10) @(posedge clk);
      wait_idle();
   endtask : trig

   initial begin
      repeat (4) @(posedge clk);
      rst <= 0;
      repeat (2) @(posedge clk);
      rd(ADDR_CFG, d, r);
      chk(d, 32'(CFG_RST));
      rd(ADDR_TIMING, d, r);
      chk(d, 32'(TIMING_RST));
      rd(ADDR_START, d, r);
      chk(d, 32'(START_RST));
      wr(8'h1c, 32'h0, r);
      chk(r, RESP_SLVERR);
      rd(8'h1c, d, r);
      chk(r, RESP_SLVERR);
      wrc(ADDR_STATUS, 32'h0);
      // divided clock period for low, middle and top divider values
      foreach (smp[k]) if (k < 3) begin
         n = (k == 0) ? 0 : (k == 1) ? 5 : 31;
         wrc(ADDR_TIMING, 32'(n));
         repeat (6 * (n + 1) + 4) @(posedge clk);
         chk(period, 2 * (n + 1));
         rd(ADDR_TIMING, d, r);
         chk(d, 32'(n));
      end
      // every sample length code, divider 1 so one conversion clock is 4 cycles
      wrc(ADDR_CFG, 32'h01f);
      for (int k = 0; k < 8; k++) begin
         wrc(ADDR_TIMING, {24'h0, k[2:0], 5'h01});
         samp_cnt = 0;
         wrc(ADDR_START, 32'h02);
         wait_idle();
         chk_rng(samp_cnt, (smp[k] - 1) * 4, smp[k] * 4 + 2);
      end
      wrc(ADDR_TIMING, 32'h00);
      for (int c = 0; c < 16; c++) run_seq(9'h01f, 8'(c));
      run_seq(9'h01f, 8'h44);
      run_seq(9'h01f, 8'h45);
      run_seq(9'h045, 8'h14);
      run_seq(9'h045, 8'h1e);
      run_seq(9'h03f, 8'h17);
      run_seq(9'h00f, 8'h03);
      // restart in mid-sequence
      wrc(ADDR_START, 32'h07);
      repeat (60) @(posedge clk);
      wrc(ADDR_START, 32'h03);
      rd(ADDR_STATUS, d, r);
      chk(d[3:0], 4'h0);
      chk(d[8], 1'b1);
      wait_idle();
      chk(seen[$], 5'h03);
      // continuous sequences, then abort by a timing write
      wrc(ADDR_CFG, 32'h02f);
      seen.delete();
      wrc(ADDR_START, 32'h22);
      repeat (150) @(posedge clk);
      chk(seen.size() > 4, 1'b1);
      wrc(ADDR_TIMING, 32'h00);
      rd(ADDR_STATUS, d, r);
      chk(d[8], 1'b0);
      chk(d[3:0], 4'h0);
      n = seen.size();
      repeat (60) @(posedge clk);
      chk(seen.size(), n);
      // external trigger with a slow core: arm, then one sequence per trigger
      lat <= 4'h9;
      wrc(ADDR_CFG, 32'h12f);
      seen.delete();
      wrc(ADDR_START, 32'h22);
      repeat (40) @(posedge clk);
      chk(seen.size(), 0);
      trig();
      repeat (40) @(posedge clk);
      chk(seen.size(), 2);
      trig();
      chk(seen.size(), 4);
      wrap_up();
   end
endmodule : astc_top_tb

// [verilog/astc_top.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - a write to the timing register aborts the running sequence.
// - sample field bits 7..5 select 4,6,8,10,12,16,20 or 24 conversion clocks.
// - divider field bits 4..0 gives conversion clock = bus clock / (2*(P+1)).
// - a write to the start register aborts and begins a new sequence.
// - with trigger enabled, one start write arms; each trigger that arrives while idle then starts a sequence.
// - a conversion starts when its sampling phase begins.
// - start bit 6 turns channel codes to special internal channels.
// - start bit 5 picks one sequence or endlessly repeated sequences.
// - with trigger enabled, repeat bit ignored; each trigger taken while idle gives one sequence.
// - multi bit clear: every conversion samples the coded channel.
// - multi bit set: one channel per conversion, starting at the code.
// - next channel is previous plus one, back to zero after the wrap channel.
// - starting above the wrap channel, first wrap goes from 15 to 0.
// - special channels off: code n selects external input n.
// - special channels on: codes 0..3 reserved, 4 high reference, 5 low reference.
// - length bits give conversions per sequence, zero meaning sixteen.
// - abort or new sequence clears the result slot counter.
module astc_top
   import astc_pkg::*;
(
   // clock, reset, enable
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // converter core side
   input  wire logic              ext_trigger,
   input  wire logic              conv_done,
   output astc_cmd_t              cmd,
   output logic                   conv_clk,
   output logic [3:0]             result_slot
);
   // ---------------- bus state
   logic              aw_held, w_held, next_aw_held, next_w_held;
   logic [ADDR_W-1:0] waddr, next_waddr;
   logic [8:0]        wdata, next_wdata;
   logic              wlane, next_wlane;
   logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0]        next_bresp, next_rresp;
   logic [31:0]       next_rdata;
   logic              do_write, wr_cfg, wr_timing, wr_start;
   // ---------------- register and sequencer state
   logic [8:0]        cfg, next_cfg;
   logic [7:0]        timing, next_timing;
   logic [7:0]        start_reg, next_start_reg;
   astc_state_t       st, next_st;
   logic [4:0]        div_cnt, next_div_cnt;
   logic              next_conv_clk;
   logic [4:0]        samp_cnt, next_samp_cnt;
   logic [4:0]        conv_num, next_conv_num;
   logic [3:0]        channel, next_channel;
   logic [3:0]        next_result_slot;
   logic              armed, next_armed;
   astc_cmd_t         next_cmd;
   logic [2:0]        trig_sync;
   logic              trig_level;
   logic              trig_edge, tick, clk_rise, last_conv, etrig, begin_seq;

   // a write lands once address and data are both held and no response is pending
   assign do_write  = aw_held && w_held && !s_axi_bvalid;
   assign wr_cfg    = do_write && wlane && (waddr == ADDR_CFG);
   assign wr_timing = do_write && wlane && (waddr == ADDR_TIMING);
   assign wr_start  = do_write && wlane && (waddr == ADDR_START);

   // bus channel bookkeeping; address and data may arrive in either order
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_waddr   = waddr;
      next_wdata   = wdata;
      next_wlane   = wlane;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_rvalid  = s_axi_rvalid;
      next_rresp   = s_axi_rresp;
      next_rdata   = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_waddr   = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_wdata  = s_axi_wdata[8:0];
         next_wlane  = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         if (waddr == ADDR_CFG || waddr == ADDR_TIMING || waddr == ADDR_START || waddr == ADDR_STATUS) begin
            next_bresp = RESP_OKAY;
         end else begin
            next_bresp = RESP_SLVERR;
         end
      end
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         if (s_axi_araddr == ADDR_CFG) begin
            next_rdata = 32'(cfg);
         end else if (s_axi_araddr == ADDR_TIMING) begin
            next_rdata = 32'(timing);
         end else if (s_axi_araddr == ADDR_START) begin
            next_rdata = 32'(start_reg);
         end else if (s_axi_araddr == ADDR_STATUS) begin
            // status: slot, channel, busy, armed
            next_rdata = 32'({armed, (st != ST_IDLE), channel, result_slot});
         end else begin
            next_rdata = 32'h0;
            next_rresp = RESP_SLVERR;
         end
      end
      // one transfer of each kind in flight: ready drops while one is held
      next_awready = !next_aw_held;
      next_wready  = !next_w_held;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         waddr         <= '0;
         wdata         <= 9'h000;
         wlane         <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_rdata   <= 32'h0;
      end else if (ce) begin
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         waddr         <= next_waddr;
         wdata         <= next_wdata;
         wlane         <= next_wlane;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rresp   <= next_rresp;
         s_axi_rdata   <= next_rdata;
      end
   end

   // trigger pin: three flops, an edge counts once the last two agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trig_sync  <= 3'h0;
         trig_level <= 1'b0;
      end else if (ce) begin
         trig_sync <= {trig_sync[1:0], ext_trigger};
         if (trig_sync[1] == trig_sync[2]) begin
            trig_level <= trig_sync[2];
         end
      end
   end
   assign trig_edge = (trig_sync[1] == trig_sync[2]) && trig_sync[2] && !trig_level;

   assign etrig     = cfg[ETRIG_BIT];
   assign tick      = (div_cnt == timing[PRS_MSB:0]);
   assign clk_rise  = tick && !conv_clk;
   assign last_conv = (conv_num + 5'h01) == astc_seq_len(cfg[LEN_MSB:LEN_LSB]);
   // a start write begins at once unless triggers own the start; a timing write beats a trigger edge
   assign begin_seq = (wr_start && !etrig) || (st == ST_IDLE && armed && etrig && trig_edge && !wr_timing);

   // registers, prescaler and sequencer
   always_comb begin
      next_cfg         = wr_cfg ? wdata : cfg;
      next_timing      = wr_timing ? wdata[7:0] : timing;
      next_start_reg   = wr_start ? wdata[7:0] : start_reg;
      next_st          = st;
      next_samp_cnt    = samp_cnt;
      next_conv_num    = conv_num;
      next_channel     = channel;
      next_result_slot = result_slot;
      next_armed       = armed;
      next_div_cnt     = tick ? 5'h00 : div_cnt + 5'h01;
      next_conv_clk    = tick ? !conv_clk : conv_clk;
      case (st)
         ST_SAMPLE: begin
            if (clk_rise) begin
               next_samp_cnt = samp_cnt + 5'h01;
               if (next_samp_cnt == astc_samp_len(timing[SMP_MSB:SMP_LSB])) begin
                  next_st = ST_CONVERT;
               end
            end
         end
         ST_CONVERT: begin
            if (conv_done) begin
               next_result_slot = result_slot + 4'h1;
               next_samp_cnt    = 5'h00;
               if (!last_conv) begin
                  next_conv_num = conv_num + 5'h01;
                  next_st       = ST_SAMPLE;
                  if (start_reg[MULTI_CHANNEL_ENABLE_BIT]) begin
                     next_channel = astc_step(channel, cfg[WRAP_MSB:0]);
                  end
               end else if (start_reg[SCAN_BIT] && !etrig) begin
                  next_conv_num    = 5'h00;
                  next_channel     = start_reg[CH_MSB:0];
                  next_result_slot = 4'h0;
                  next_st          = ST_SAMPLE;
               end else begin
                  next_st = ST_IDLE;
               end
            end
         end
         default: begin
         end
      endcase
      // abort on any timing write; the divider restarts with the new value
      if (wr_timing) begin
         next_st          = ST_IDLE;
         next_result_slot = 4'h0;
         next_armed       = 1'b0;
         next_div_cnt     = 5'h00;
         next_conv_clk    = 1'b0;
      end
      if (wr_start) begin
         next_st          = ST_IDLE;
         next_result_slot = 4'h0;
         next_armed       = etrig;
      end
      if (begin_seq) begin
         next_st          = ST_SAMPLE;
         next_samp_cnt    = 5'h00;
         next_conv_num    = 5'h00;
         next_result_slot = 4'h0;
         next_channel     = wr_start ? wdata[CH_MSB:0] : start_reg[CH_MSB:0];
      end
      // start pulse marks the first cycle of sampling; a restart inside sampling pulses again
      next_cmd.start   = (next_st == ST_SAMPLE) && ((st != ST_SAMPLE) || begin_seq);
      next_cmd.sample  = (next_st == ST_SAMPLE);
      next_cmd.special = next_start_reg[SC_BIT];
      next_cmd.channel = next_channel;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg         <= CFG_RST;
         timing      <= TIMING_RST;
         start_reg   <= START_RST;
         st          <= ST_IDLE;
         div_cnt     <= 5'h00;
         conv_clk    <= 1'b0;
         samp_cnt    <= 5'h00;
         conv_num    <= 5'h00;
         channel     <= 4'h0;
         result_slot <= 4'h0;
         armed       <= 1'b0;
         cmd         <= '0;
      end else if (ce) begin
         cfg         <= next_cfg;
         timing      <= next_timing;
         start_reg   <= next_start_reg;
         st          <= next_st;
         div_cnt     <= next_div_cnt;
         conv_clk    <= next_conv_clk;
         samp_cnt    <= next_samp_cnt;
         conv_num    <= next_conv_num;
         channel     <= next_channel;
         result_slot <= next_result_slot;
         armed       <= next_armed;
         cmd         <= next_cmd;
      end
   end

   // checks
   sequence s_timing_wr;
      ce && wr_timing;
   endsequence
   sequence s_idle_clear;
      st == ST_IDLE && result_slot == 4'h0 && !cmd.sample;
   endsequence
   timing_abort_a: assert property (@(posedge clk) disable iff (rst) s_timing_wr |=> s_idle_clear)
      else $error("timing write did not abort");
   start_write_a: assert property (@(posedge clk) disable iff (rst)
      ce && wr_start && !etrig |=> st == ST_SAMPLE && cmd.start && conv_num == 5'h00 && result_slot == 4'h0)
      else $error("start write did not begin a sequence");
   sample_len_a: assert property (@(posedge clk) disable iff (rst)
      ce && st == ST_SAMPLE && clk_rise && !wr_timing && !wr_start
      && samp_cnt == astc_samp_len(timing[SMP_MSB:SMP_LSB]) - 5'h01 |=> st == ST_CONVERT)
      else $error("sample phase length wrong");
   prescale_a: assert property (@(posedge clk) disable iff (rst)
      ce && !wr_timing |=> (conv_clk != $past(conv_clk)) == ($past(div_cnt) == $past(timing[PRS_MSB:0])))
      else $error("conversion clock divider wrong");
   start_sample_a: assert property (@(posedge clk) disable iff (rst) cmd.start |-> cmd.sample ##1 !cmd.start)
      else $error("start not at sampling begin");
   single_chan_a: assert property (@(posedge clk) disable iff (rst)
      cmd.sample && !start_reg[MULTI_CHANNEL_ENABLE_BIT] |-> cmd.channel == start_reg[CH_MSB:0])
      else $error("single channel mode moved channel");
   chan_step_a: assert property (@(posedge clk) disable iff (rst)
      ce && st == ST_CONVERT && conv_done && !last_conv && start_reg[MULTI_CHANNEL_ENABLE_BIT] && !wr_timing && !wr_start
      |=> channel == astc_step($past(channel), cfg[WRAP_MSB:0]))
      else $error("channel step wrong");
   trig_once_a: assert property (@(posedge clk) disable iff (rst)
      ce && st == ST_CONVERT && conv_done && last_conv && etrig && !wr_start |=> st == ST_IDLE)
      else $error("trigger mode repeated a sequence");
   seq_len_a: assert property (@(posedge clk) disable iff (rst)
      st != ST_IDLE |-> conv_num < astc_seq_len(cfg[LEN_MSB:LEN_LSB]))
      else $error("too many conversions in sequence");
   special_a: assert property (@(posedge clk) disable iff (rst) ce && !wr_start |=> $stable(cmd.special))
      else $error("special channel flag changed without a start write");
endmodule : astc_top
